// >>> src/ped_dispatcher.v
// prioritized event dispatcher: latches peripheral events and offers the next one to service
`default_nettype none
`include "ped_consts.vh"

module ped_dispatcher #(
  parameter NUM_EVT = `PED_NUM_EVT,
  parameter EVT_W = `PED_EVT_W,
  parameter LVL_W = `PED_LVL_W,
  parameter NUM_IN = `PED_NUM_IN
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // control from the execution engine
  input wire global_enable,
  input wire [NUM_EVT-1:0] evt_enable,
  input wire svc_take,
  // serial port zero
  input wire s0_rx_char,
  input wire s0_tx_done,
  input wire s0_rx_msg,
  // serial port one
  input wire s1_rx_msg,
  input wire s1_rx_char,
  input wire s1_tx_done,
  // pulse train outputs
  input wire pulse_train_output_zero_done,
  input wire pulse_train_output_one_done,
  // input bits, edges detected here
  input wire [NUM_IN-1:0] input_bits,
  // fast counter zero
  input wire fast_counter_zero_match,
  input wire fast_counter_zero_dir_chg,
  input wire fast_counter_zero_ext_rst,
  // fast counter one
  input wire fast_counter_one_match,
  input wire fast_counter_one_dir_chg,
  input wire fast_counter_one_ext_rst,
  // fast counter two
  input wire fast_counter_two_match,
  input wire fast_counter_two_dir_chg,
  input wire fast_counter_two_ext_rst,
  // fast counters three to five
  input wire fast_counter_three_match,
  input wire fast_counter_four_match,
  input wire fast_counter_four_dir_chg,
  input wire fast_counter_four_ext_rst,
  input wire fast_counter_five_match,
  // timed sources
  input wire periodic_zero,
  input wire periodic_one,
  input wire fast_delay_timer_a_expired,
  input wire fast_delay_timer_b_expired,
  // offer to the execution engine
  output reg svc_valid,
  output reg [EVT_W-1:0] svc_event,
  output reg [1:0] svc_group,
  output reg [LVL_W-1:0] svc_level,
  output reg [NUM_EVT-1:0] pending,
  output reg evt_lost
);

  // ------------------------------------------------------------
  // fixed service order: rank index to event number
  // ------------------------------------------------------------
  function [EVT_W-1:0] rank_evt;
    input integer r;
    begin
      case (r)
        0: rank_evt = `PED_EV_S0_RX_CHAR;
        1: rank_evt = `PED_EV_S0_TX_DONE;
        2: rank_evt = `PED_EV_S0_RX_MSG;
        3: rank_evt = `PED_EV_S1_RX_MSG;
        4: rank_evt = `PED_EV_S1_RX_CHAR;
        5: rank_evt = `PED_EV_S1_TX_DONE;
        6: rank_evt = `PED_EV_PT0_DONE;
        7: rank_evt = `PED_EV_PT1_DONE;
        8: rank_evt = `PED_EV_IN0_RISE;
        9: rank_evt = `PED_EV_IN1_RISE;
        10: rank_evt = `PED_EV_IN2_RISE;
        11: rank_evt = `PED_EV_IN3_RISE;
        12: rank_evt = `PED_EV_IN0_FALL;
        13: rank_evt = `PED_EV_IN1_FALL;
        14: rank_evt = `PED_EV_IN2_FALL;
        15: rank_evt = `PED_EV_IN3_FALL;
        16: rank_evt = `PED_EV_FC0_MATCH;
        17: rank_evt = `PED_EV_FC0_DIR;
        18: rank_evt = `PED_EV_FC0_RST;
        19: rank_evt = `PED_EV_FC1_MATCH;
        20: rank_evt = `PED_EV_FC1_DIR;
        21: rank_evt = `PED_EV_FC1_RST;
        22: rank_evt = `PED_EV_FC2_MATCH;
        23: rank_evt = `PED_EV_FC2_DIR;
        24: rank_evt = `PED_EV_FC2_RST;
        25: rank_evt = `PED_EV_FC3_MATCH;
        26: rank_evt = `PED_EV_FC4_MATCH;
        27: rank_evt = `PED_EV_FC4_DIR;
        28: rank_evt = `PED_EV_FC4_RST;
        29: rank_evt = `PED_EV_FC5_MATCH;
        30: rank_evt = `PED_EV_PERIODIC0;
        31: rank_evt = `PED_EV_PERIODIC1;
        32: rank_evt = `PED_EV_TMR_A;
        33: rank_evt = `PED_EV_TMR_B;
        default: rank_evt = `PED_EV_IN0_RISE;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // group and in-group level of each rank
  // ------------------------------------------------------------
  // spelled out per rank rather than derived from it, so a change
  // to the order cannot silently shift a level
  function [LVL_W+1:0] rank_code;
    input integer r;
    begin
      case (r)
        0: rank_code = {`PED_GRP_COMM, 5'h00};
        1: rank_code = {`PED_GRP_COMM, 5'h00};
        2: rank_code = {`PED_GRP_COMM, 5'h00};
        3: rank_code = {`PED_GRP_COMM, 5'h01};
        4: rank_code = {`PED_GRP_COMM, 5'h01};
        5: rank_code = {`PED_GRP_COMM, 5'h01};
        6: rank_code = {`PED_GRP_DISC, 5'h00};
        7: rank_code = {`PED_GRP_DISC, 5'h01};
        8: rank_code = {`PED_GRP_DISC, 5'h02};
        9: rank_code = {`PED_GRP_DISC, 5'h03};
        10: rank_code = {`PED_GRP_DISC, 5'h04};
        11: rank_code = {`PED_GRP_DISC, 5'h05};
        12: rank_code = {`PED_GRP_DISC, 5'h06};
        13: rank_code = {`PED_GRP_DISC, 5'h07};
        14: rank_code = {`PED_GRP_DISC, 5'h08};
        15: rank_code = {`PED_GRP_DISC, 5'h09};
        16: rank_code = {`PED_GRP_DISC, 5'h0A};
        17: rank_code = {`PED_GRP_DISC, 5'h0B};
        18: rank_code = {`PED_GRP_DISC, 5'h0C};
        19: rank_code = {`PED_GRP_DISC, 5'h0D};
        20: rank_code = {`PED_GRP_DISC, 5'h0E};
        21: rank_code = {`PED_GRP_DISC, 5'h0F};
        22: rank_code = {`PED_GRP_DISC, 5'h10};
        23: rank_code = {`PED_GRP_DISC, 5'h11};
        24: rank_code = {`PED_GRP_DISC, 5'h12};
        25: rank_code = {`PED_GRP_DISC, 5'h13};
        26: rank_code = {`PED_GRP_DISC, 5'h14};
        27: rank_code = {`PED_GRP_DISC, 5'h15};
        28: rank_code = {`PED_GRP_DISC, 5'h16};
        29: rank_code = {`PED_GRP_DISC, 5'h17};
        30: rank_code = {`PED_GRP_TIMED, 5'h00};
        31: rank_code = {`PED_GRP_TIMED, 5'h01};
        32: rank_code = {`PED_GRP_TIMED, 5'h02};
        33: rank_code = {`PED_GRP_TIMED, 5'h03};
        default: rank_code = {`PED_GRP_COMM, 5'h00};
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // input edge detection
  // ------------------------------------------------------------
  // no edge is reported until one sample has been taken, so a pin
  // already high at reset release does not fake a rising edge
  reg [NUM_IN-1:0] in_prev_reg;
  reg in_primed_reg;
  wire [NUM_IN-1:0] in_rise;
  wire [NUM_IN-1:0] in_fall;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_prev_reg <= {NUM_IN{1'b0}};
      in_primed_reg <= 1'b0;
    end else begin
      in_prev_reg <= input_bits;
      in_primed_reg <= 1'b1;
    end
  end

  assign in_rise = {NUM_IN{in_primed_reg}} & input_bits & ~in_prev_reg;
  assign in_fall = {NUM_IN{in_primed_reg}} & ~input_bits & in_prev_reg;

  // ------------------------------------------------------------
  // raw event vector, indexed by event number
  // ------------------------------------------------------------
  reg [NUM_EVT-1:0] raw_evt;

  always @* begin
    raw_evt = {NUM_EVT{1'b0}};
    raw_evt[`PED_EV_IN0_RISE] = in_rise[0];
    raw_evt[`PED_EV_IN0_FALL] = in_fall[0];
    raw_evt[`PED_EV_IN1_RISE] = in_rise[1];
    raw_evt[`PED_EV_IN1_FALL] = in_fall[1];
    raw_evt[`PED_EV_IN2_RISE] = in_rise[2];
    raw_evt[`PED_EV_IN2_FALL] = in_fall[2];
    raw_evt[`PED_EV_IN3_RISE] = in_rise[3];
    raw_evt[`PED_EV_IN3_FALL] = in_fall[3];
    raw_evt[`PED_EV_S0_RX_CHAR] = s0_rx_char;
    raw_evt[`PED_EV_S0_TX_DONE] = s0_tx_done;
    raw_evt[`PED_EV_S0_RX_MSG] = s0_rx_msg;
    raw_evt[`PED_EV_S1_RX_MSG] = s1_rx_msg;
    raw_evt[`PED_EV_S1_RX_CHAR] = s1_rx_char;
    raw_evt[`PED_EV_S1_TX_DONE] = s1_tx_done;
    raw_evt[`PED_EV_PT0_DONE] = pulse_train_output_zero_done;
    raw_evt[`PED_EV_PT1_DONE] = pulse_train_output_one_done;
    raw_evt[`PED_EV_FC0_MATCH] = fast_counter_zero_match;
    raw_evt[`PED_EV_FC0_DIR] = fast_counter_zero_dir_chg;
    raw_evt[`PED_EV_FC0_RST] = fast_counter_zero_ext_rst;
    raw_evt[`PED_EV_FC1_MATCH] = fast_counter_one_match;
    raw_evt[`PED_EV_FC1_DIR] = fast_counter_one_dir_chg;
    raw_evt[`PED_EV_FC1_RST] = fast_counter_one_ext_rst;
    raw_evt[`PED_EV_FC2_MATCH] = fast_counter_two_match;
    raw_evt[`PED_EV_FC2_DIR] = fast_counter_two_dir_chg;
    raw_evt[`PED_EV_FC2_RST] = fast_counter_two_ext_rst;
    raw_evt[`PED_EV_FC3_MATCH] = fast_counter_three_match;
    raw_evt[`PED_EV_FC4_MATCH] = fast_counter_four_match;
    raw_evt[`PED_EV_FC4_DIR] = fast_counter_four_dir_chg;
    raw_evt[`PED_EV_FC4_RST] = fast_counter_four_ext_rst;
    raw_evt[`PED_EV_FC5_MATCH] = fast_counter_five_match;
    raw_evt[`PED_EV_PERIODIC0] = periodic_zero;
    raw_evt[`PED_EV_PERIODIC1] = periodic_one;
    raw_evt[`PED_EV_TMR_A] = fast_delay_timer_a_expired;
    raw_evt[`PED_EV_TMR_B] = fast_delay_timer_b_expired;
  end

  // ------------------------------------------------------------
  // pending flags
  // ------------------------------------------------------------
  // events not enabled are dropped, not queued; a pending event
  // that fires again outside its take cycle is counted once and flagged as lost
  wire [NUM_EVT-1:0] set_evt;
  wire take_now;
  reg [NUM_EVT-1:0] clr_evt;
  reg [NUM_EVT-1:0] pending_next;
  wire lost_next;

  assign set_evt = raw_evt & evt_enable;
  assign take_now = svc_valid & svc_take;

  always @* begin
    clr_evt = {NUM_EVT{1'b0}};
    if (take_now) begin
      clr_evt[svc_event] = 1'b1;
    end
    // a new arrival wins over the clear of the same flag
    pending_next = (pending & ~clr_evt) | set_evt;
  end

  assign lost_next = |(set_evt & pending & ~clr_evt);

  // ------------------------------------------------------------
  // rank scan over pending flags
  // ------------------------------------------------------------
  // scanning from the last rank down to rank 0 lets rank 0
  // overwrite; the chain is long but one cycle at 40 ns is ample
  integer i;
  reg sel_hit;
  reg [EVT_W-1:0] sel_evt;
  reg [1:0] sel_grp;
  reg [LVL_W-1:0] sel_lvl;

  always @* begin
    sel_hit = 1'b0;
    sel_evt = {EVT_W{1'b0}};
    sel_grp = `PED_GRP_COMM;
    sel_lvl = {LVL_W{1'b0}};
    for (i = NUM_EVT - 1; i >= 0; i = i - 1) begin
      if (pending[rank_evt(i)]) begin
        sel_hit = 1'b1;
        sel_evt = rank_evt(i);
        {sel_grp, sel_lvl} = rank_code(i);
      end
    end
  end

  // ------------------------------------------------------------
  // offer register
  // ------------------------------------------------------------
  // the offer holds steady until taken; a higher event arriving
  // meanwhile waits, which keeps the engine's view consistent
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pending <= {NUM_EVT{1'b0}};
      evt_lost <= 1'b0;
      svc_valid <= 1'b0;
      svc_event <= {EVT_W{1'b0}};
      svc_group <= 2'h0;
      svc_level <= {LVL_W{1'b0}};
    end else begin
      pending <= pending_next;
      evt_lost <= lost_next;
      if (take_now) begin
        svc_valid <= 1'b0;
      end else if (!svc_valid && global_enable && sel_hit) begin
        svc_valid <= 1'b1;
        svc_event <= sel_evt;
        svc_group <= sel_grp;
        svc_level <= sel_lvl;
      end
    end
  end

endmodule

`default_nettype wire

// >>> src/ped_consts.vh
// event numbers, group codes and rank boundaries of the event dispatcher
`ifndef PED_CONSTS_VH
`define PED_CONSTS_VH

// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define PED_NUM_EVT 34
`define PED_EVT_W 6
`define PED_LVL_W 5
`define PED_NUM_IN 4

// ------------------------------------------------------------
// priority groups
// ------------------------------------------------------------
`define PED_GRP_COMM 2'h0
`define PED_GRP_DISC 2'h1
`define PED_GRP_TIMED 2'h2

// ------------------------------------------------------------
// rank boundaries (rank 0 is serviced first)
// ------------------------------------------------------------
`define PED_RANK_DISC_FIRST 6
`define PED_RANK_TIMED_FIRST 30
`define PED_COMM_PER_LEVEL 3

// ------------------------------------------------------------
// event numbers
// ------------------------------------------------------------
`define PED_EV_IN0_RISE 6'h00
`define PED_EV_IN0_FALL 6'h01
`define PED_EV_IN1_RISE 6'h02
`define PED_EV_IN1_FALL 6'h03
`define PED_EV_IN2_RISE 6'h04
`define PED_EV_IN2_FALL 6'h05
`define PED_EV_IN3_RISE 6'h06
`define PED_EV_IN3_FALL 6'h07
`define PED_EV_S0_RX_CHAR 6'h08
`define PED_EV_S0_TX_DONE 6'h09
`define PED_EV_PERIODIC0 6'h0A
`define PED_EV_PERIODIC1 6'h0B
`define PED_EV_FC0_MATCH 6'h0C
`define PED_EV_FC1_MATCH 6'h0D
`define PED_EV_FC1_DIR 6'h0E
`define PED_EV_FC1_RST 6'h0F
`define PED_EV_FC2_MATCH 6'h10
`define PED_EV_FC2_DIR 6'h11
`define PED_EV_FC2_RST 6'h12
`define PED_EV_PT0_DONE 6'h13
`define PED_EV_PT1_DONE 6'h14
`define PED_EV_TMR_A 6'h15
`define PED_EV_TMR_B 6'h16
`define PED_EV_S0_RX_MSG 6'h17
`define PED_EV_S1_RX_MSG 6'h18
`define PED_EV_S1_RX_CHAR 6'h19
`define PED_EV_S1_TX_DONE 6'h1A
`define PED_EV_FC0_DIR 6'h1B
`define PED_EV_FC0_RST 6'h1C
`define PED_EV_FC4_MATCH 6'h1D
`define PED_EV_FC4_DIR 6'h1E
`define PED_EV_FC4_RST 6'h1F
`define PED_EV_FC3_MATCH 6'h20
`define PED_EV_FC5_MATCH 6'h21

`endif

// >>> test/ped_dispatcher_sva.sv
// assertions on the event dispatcher ports
`default_nettype none
module ped_dispatcher_sva #(parameter NUM_EVT = 34, parameter EVT_W = 6, parameter LVL_W = 5) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // engine side
  input wire global_enable,
  input wire [NUM_EVT-1:0] evt_enable,
  input wire svc_take,
  input wire svc_valid,
  input wire [EVT_W-1:0] svc_event,
  input wire [1:0] svc_group,
  input wire [LVL_W-1:0] svc_level,
  input wire [NUM_EVT-1:0] pending,
  input wire evt_lost
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] ORD [34] = '{8, 9, 23, 24, 25, 26, 19, 20, 0, 2, 4, 6, 1, 3, 5, 7,
    12, 27, 28, 13, 14, 15, 16, 17, 18, 32, 29, 30, 31, 33, 10, 11, 21, 22};
  localparam logic [NUM_EVT-1:0] ONE = 1;
  int best;
  int cur;
  function automatic int rank_of(input logic [EVT_W-1:0] e);
    for (int i = 0; i < 34; i++)
      if (ORD[i] == e) return i;
    return 63;
  endfunction
  // -------------------------------------------
  // best pending rank, 63 when nothing pending
  // -------------------------------------------
  always_comb begin
    best = 63;
    for (int i = 33; i >= 0; i--)
      if (pending[ORD[i]]) best = i;
  end
  always_comb cur = rank_of(svc_event);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_take; svc_valid && svc_take; endsequence
  sequence s_hold; svc_valid && !svc_take; endsequence
  a_take_drop: assert property (s_take |=> !svc_valid)
    else $error("offer not withdrawn after take");
  a_offer_hold: assert property (s_hold |=> svc_valid && $stable(svc_event)
    && $stable(svc_group) && $stable(svc_level)) else $error("standing offer changed");
  a_offer_pend: assert property (svc_valid |-> pending[svc_event])
    else $error("offered event not pending");
  a_offer_gate: assert property ($rose(svc_valid) |-> $past(global_enable))
    else $error("offer made while disabled");
  a_offer_rank: assert property (svc_valid |->
    svc_group == (cur < 6 ? 0 : cur < 30 ? 1 : 2) &&
    svc_level == (cur < 6 ? cur / 3 : cur < 30 ? cur - 6 : cur - 30))
    else $error("group or level wrong for event");
  a_best_pick: assert property ($rose(svc_valid) |-> cur == $past(best))
    else $error("offer is not the best pending event");
  a_drop_off: assert property (!(|(pending & ~$past(pending) & ~$past(evt_enable))))
    else $error("disabled event latched");
  a_pend_keep: assert property (|($past(pending) & ~pending) |->
    $past(svc_take) && $past(svc_valid) &&
    (($past(pending) & ~pending) == ONE << $past(svc_event)))
    else $error("pending flag lost without take");
  a_lost_cause: assert property (evt_lost |-> |($past(pending) & pending))
    else $error("lost flag without a standing pending event");
endmodule
bind ped_dispatcher ped_dispatcher_sva #(.NUM_EVT(NUM_EVT), .EVT_W(EVT_W), .LVL_W(LVL_W)) u_sva (
  .clk(clk), .arst_n(arst_n), .global_enable(global_enable), .evt_enable(evt_enable),
  .svc_take(svc_take), .svc_valid(svc_valid), .svc_event(svc_event), .svc_group(svc_group),
  .svc_level(svc_level), .pending(pending), .evt_lost(evt_lost));
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the event dispatcher
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic arst_n = 0;
  logic global_enable = 0;
  logic [33:0] evt_enable = '1;
  logic svc_take = 0;
  logic [33:0] ev = '0;
  logic [3:0] input_bits = 4'h0;
  wire svc_valid;
  wire [5:0] svc_event;
  wire [1:0] svc_group;
  wire [4:0] svc_level;
  wire [33:0] pending;
  wire evt_lost;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  localparam logic [5:0] ORD [34] = '{8, 9, 23, 24, 25, 26, 19, 20, 0, 2, 4, 6, 1, 3, 5, 7,
    12, 27, 28, 13, 14, 15, 16, 17, 18, 32, 29, 30, 31, 33, 10, 11, 21, 22};
  // edge events 0..7 come from input_bits, so ev[7:0] stays unused
  ped_dispatcher uut (.clk(clk), .arst_n(arst_n), .global_enable(global_enable),
    .evt_enable(evt_enable), .svc_take(svc_take), .s0_rx_char(ev[8]), .s0_tx_done(ev[9]),
    .s0_rx_msg(ev[23]), .s1_rx_msg(ev[24]), .s1_rx_char(ev[25]), .s1_tx_done(ev[26]),
    .pulse_train_output_zero_done(ev[19]), .pulse_train_output_one_done(ev[20]),
    .input_bits(input_bits), .fast_counter_zero_match(ev[12]),
    .fast_counter_zero_dir_chg(ev[27]), .fast_counter_zero_ext_rst(ev[28]),
    .fast_counter_one_match(ev[13]), .fast_counter_one_dir_chg(ev[14]),
    .fast_counter_one_ext_rst(ev[15]), .fast_counter_two_match(ev[16]),
    .fast_counter_two_dir_chg(ev[17]), .fast_counter_two_ext_rst(ev[18]),
    .fast_counter_three_match(ev[32]), .fast_counter_four_match(ev[29]),
    .fast_counter_four_dir_chg(ev[30]), .fast_counter_four_ext_rst(ev[31]),
    .fast_counter_five_match(ev[33]), .periodic_zero(ev[10]), .periodic_one(ev[11]),
    .fast_delay_timer_a_expired(ev[21]), .fast_delay_timer_b_expired(ev[22]),
    .svc_valid(svc_valid), .svc_event(svc_event), .svc_group(svc_group),
    .svc_level(svc_level), .pending(pending), .evt_lost(evt_lost));
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(input int n);
    ev[n] = 1'b1;
    @(negedge clk);
    ev[n] = 1'b0;
  endtask
  // offers may lag a take by a cycle or two, so the wait is bounded, not fixed
  task automatic wait_valid();
    int k;
    for (k = 0; k < 4 && svc_valid !== 1'b1; k++) @(negedge clk);
  endtask
  task automatic take_one(input logic [5:0] e, input logic [1:0] g, input logic [4:0] l);
    wait_valid();
    chk({svc_valid, svc_event, svc_group, svc_level}, {1'b1, e, g, l});
    svc_take = 1'b1;
    @(negedge clk);
    svc_take = 1'b0;
    chk(svc_valid, 0);
  endtask
  // -------------------------------------------
  // scenarios
  // -------------------------------------------
  task automatic t_order();
    logic [1:0] grp;
    logic [4:0] lvl;
    ev = 34'h3FFFFFF00;
    input_bits = 4'hF;
    @(negedge clk);
    ev = '0;
    input_bits = 4'h0;
    @(negedge clk);
    chk({svc_valid, pending}, 35'h3FFFFFFFF);
    chk({pending[33:29], pending[22:21]}, 7'h7F);
    global_enable = 1'b1;
    for (int i = 0; i < 34; i++) begin
      grp = i < 6 ? 2'h0 : i < 30 ? 2'h1 : 2'h2;
      lvl = i < 6 ? 5'(i / 3) : i < 30 ? 5'(i - 6) : 5'(i - 30);
      take_one(ORD[i], grp, lvl);
      chk(pending[ORD[i]], 0);
    end
    $display("test order done");
  endtask
  task automatic t_refuse();
    global_enable = 1'b0;
    evt_enable[12] = 1'b0;
    pulse(12);
    chk(pending, 0);
    evt_enable = '1;
    pulse(10);
    svc_take = 1'b1;
    @(negedge clk);
    svc_take = 1'b0;
    chk({svc_valid, pending}, 35'h400);
    global_enable = 1'b1;
    take_one(6'h0A, 2'h2, 5'h00);
    $display("test refuse done");
  endtask
  task automatic t_merge();
    logic lost;
    global_enable = 1'b0;
    pulse(25);
    chk(evt_lost, 0);
    pulse(25);
    lost = evt_lost;
    @(negedge clk);
    lost = lost | evt_lost;
    chk(lost, 1);
    global_enable = 1'b1;
    wait_valid();
    pulse(8);
    chk(svc_event, 6'h19);
    take_one(6'h19, 2'h0, 5'h01);
    wait_valid();
    chk(svc_event, 6'h08);
    ev[8] = 1'b1;
    svc_take = 1'b1;
    @(negedge clk);
    ev[8] = 1'b0;
    svc_take = 1'b0;
    chk(pending, 34'h100);
    take_one(6'h08, 2'h0, 5'h00);
    chk(pending, 0);
    $display("test merge done");
  endtask
  task automatic t_reset();
    global_enable = 1'b0;
    pulse(11);
    // a pin already high across the release must not fake a rising edge
    input_bits = 4'h1;
    arst_n = 1'b0;
    @(negedge clk);
    chk({svc_valid, evt_lost, pending}, 0);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk({svc_valid, evt_lost, pending}, 0);
    input_bits = 4'h0;
    @(negedge clk);
    chk(pending, 34'h2);
    global_enable = 1'b1;
    take_one(6'h01, 2'h1, 5'h06);
    $display("test reset done");
  endtask
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_order();
    t_refuse();
    t_merge();
    t_reset();
    end_sim();
  end
endmodule
`default_nettype wire
